// >>> core/qaw_pkg.sv
// constants, types and field layouts of the q&a watchdog state registers
// assumes an upstream serial port that decodes frames into byte accesses
package qaw_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   // offsets reach past 0x7f, so the address is a full byte
   localparam logic [7:0] QAW_OFS_CONFIG   = 8'h47;
   localparam logic [7:0] QAW_OFS_STATUS   = 8'h77;
   localparam logic [7:0] QAW_OFS_QUESTION = 8'h80;
   localparam logic [7:0] QAW_OFS_ANSWER   = 8'h81;
   localparam logic [7:0] QAW_OFS_FAILCNT  = 8'h82;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         QAW_CFG_DEBUG_BIT = 7;
   localparam int         QAW_CFG_OFF_BIT   = 6;
   localparam logic [2:0] QAW_PERIOD_RST    = 3'h4;
   localparam logic       QAW_OFF_RST       = 1'h0;
   localparam logic       QAW_DEBUG_RST     = 1'h0;
   localparam logic [1:0] QAW_FAILCNT_RST   = 2'h2;
   localparam logic [1:0] QAW_FAILCNT_LOAD  = 2'h2;
   localparam logic [2:0] QAW_CAUSE_RST     = 3'h0;
   localparam logic [2:0] QAW_CAUSE_RSVD    = 3'h5;

   // ****************************************
   // operating modes seen from mode control
   // ****************************************
   typedef enum logic [2:0] {
      QAW_MODE_NORMAL  = 3'h0,
      QAW_MODE_LISTEN  = 3'h1,
      QAW_MODE_STANDBY = 3'h2,
      QAW_MODE_SLEEP   = 3'h3,
      QAW_MODE_OTHER   = 3'h4
   } qaw_mode_e;

   // outcome of one evaluated trigger, moved as one word
   typedef struct packed {
      logic [2:0] trigger_position_field;
      logic       missed_trigger_flag;
      logic       early_trigger_flag;
   } qaw_trig_s;

   localparam qaw_trig_s QAW_TRIG_RST = '{3'h0, 1'h0, 1'h0};

   // configuration bits steering the watchdog core
   typedef struct packed {
      logic       wd_debug_enable;
      logic       wd_standby_off_ctrl;
      logic [2:0] wd_period_select;
   } qaw_cfg_s;

   localparam qaw_cfg_s QAW_CFG_RST = '{QAW_DEBUG_RST, QAW_OFF_RST, QAW_PERIOD_RST};

endpackage : qaw_pkg

// >>> core/qaw_regs.sv
// watchdog configuration and status registers of the q&a watchdog
// assumes byte accesses decoded by the serial port on the same clock,
// and event pulses from the watchdog core and mode control on clk
`timescale 1ns/1ns
`default_nettype none

module qaw_regs (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // register access from the serial port
   input  wire logic [7:0]           reg_addr,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_wdata,
   output var  logic [7:0]           reg_rdata,
   // mode and device state
   input  wire qaw_pkg::qaw_mode_e   mode_control,
   input  wire logic                 software_development_mode,
   input  wire logic                 rxd_int_pending,
   // events from the watchdog core
   input  wire logic                 fail_counter_increment_event,
   input  wire logic                 cause_load,
   input  wire logic [2:0]           cause_code,
   input  wire logic                 trig_eval,
   input  wire qaw_pkg::qaw_trig_s   trig_result,
   input  wire logic [7:0]           question_in,
   // steering towards the watchdog core
   output var  qaw_pkg::qaw_cfg_s    wd_cfg,
   output var  logic                 watchdog_held_reset_state,
   output var  logic [1:0]           fail_counter,
   output var  logic                 answer_strobe,
   output var  logic [7:0]           answer_value
);
   import qaw_pkg::*;

   // ****************************************
   // state
   // ****************************************
   qaw_cfg_s   cfg_r, cfg_nxt;
   qaw_trig_s  trig_r, trig_nxt;
   logic [2:0] cause_r, cause_nxt;
   logic [7:0] question_r, question_nxt;
   logic [1:0] fc_r, fc_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       held_r, held_nxt;
   logic       ans_stb_r, ans_stb_nxt;
   logic [7:0] ans_r, ans_nxt;
   qaw_mode_e  mode_prev_r;
   logic       sleep_entry;
   logic       wr_cfg, wr_fc, wr_ans;

   // decode of write targets
   assign wr_cfg = reg_wr && (reg_addr == QAW_OFS_CONFIG);
   assign wr_fc  = reg_wr && (reg_addr == QAW_OFS_FAILCNT);
   assign wr_ans = reg_wr && (reg_addr == QAW_OFS_ANSWER);

   // sleep entry only counts when coming from an active or standby mode
   assign sleep_entry = (mode_control == QAW_MODE_SLEEP) &&
                        ((mode_prev_r == QAW_MODE_NORMAL) ||
                         (mode_prev_r == QAW_MODE_LISTEN) ||
                         (mode_prev_r == QAW_MODE_STANDBY));

   // ****************************************
   // configuration register
   // ****************************************
   // the default reload is last so it beats a simultaneous host write
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt.wd_debug_enable = reg_wdata[QAW_CFG_DEBUG_BIT] && software_development_mode;
         cfg_nxt.wd_standby_off_ctrl = reg_wdata[QAW_CFG_OFF_BIT];
         cfg_nxt.wd_period_select = reg_wdata[2:0];
      end
      if (!software_development_mode) begin
         cfg_nxt.wd_debug_enable = 1'h0;
      end
      if (fail_counter_increment_event || sleep_entry ||
          ((mode_control == QAW_MODE_STANDBY) && rxd_int_pending)) begin
         cfg_nxt.wd_standby_off_ctrl = QAW_OFF_RST;
      end
      if (fail_counter_increment_event || sleep_entry) begin
         cfg_nxt.wd_period_select = QAW_PERIOD_RST;
      end
   end

   // ****************************************
   // status, question and fail counter
   // ****************************************
   always_comb begin
      trig_nxt = trig_r;
      cause_nxt = cause_r;
      question_nxt = question_in;
      fc_nxt = fc_r;
      if (trig_eval) begin
         trig_nxt = trig_result;
      end
      if (cause_load && (cause_code != QAW_CAUSE_RSVD)) begin
         cause_nxt = cause_code;
      end
      if (wr_fc) begin
         fc_nxt = reg_wdata[1:0];
      end
      if (fail_counter_increment_event || sleep_entry) begin
         fc_nxt = QAW_FAILCNT_LOAD;
      end
   end

   // ****************************************
   // read data, answer strobe, hold state
   // ****************************************
   // reserved and unmapped bits read as zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            QAW_OFS_CONFIG:   rdata_nxt = {cfg_r.wd_debug_enable, cfg_r.wd_standby_off_ctrl,
                                           3'h0, cfg_r.wd_period_select};
            QAW_OFS_STATUS:   rdata_nxt = {cause_r, trig_r};
            QAW_OFS_QUESTION: rdata_nxt = question_r;
            QAW_OFS_ANSWER:   rdata_nxt = 8'h00;
            QAW_OFS_FAILCNT:  rdata_nxt = {6'h00, fc_r};
            default:          rdata_nxt = 8'h00;
         endcase
      end
      ans_stb_nxt = wr_ans;
      ans_nxt = wr_ans ? reg_wdata : ans_r;
      held_nxt = cfg_r.wd_standby_off_ctrl && (mode_control == QAW_MODE_STANDBY) &&
                 !rxd_int_pending;
   end

   // registers, all outputs come from these
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_r       <= QAW_CFG_RST;
         trig_r      <= QAW_TRIG_RST;
         cause_r     <= QAW_CAUSE_RST;
         question_r  <= 8'h00;
         fc_r        <= QAW_FAILCNT_RST;
         rdata_r     <= 8'h00;
         held_r      <= 1'h0;
         ans_stb_r   <= 1'h0;
         ans_r       <= 8'h00;
         mode_prev_r <= QAW_MODE_OTHER;
      end else begin
         cfg_r       <= cfg_nxt;
         trig_r      <= trig_nxt;
         cause_r     <= cause_nxt;
         question_r  <= question_nxt;
         fc_r        <= fc_nxt;
         rdata_r     <= rdata_nxt;
         held_r      <= held_nxt;
         ans_stb_r   <= ans_stb_nxt;
         ans_r       <= ans_nxt;
         mode_prev_r <= mode_control;
      end
   end

   assign wd_cfg                    = cfg_r;
   assign watchdog_held_reset_state = held_r;
   assign fail_counter              = fc_r;
   assign answer_strobe             = ans_stb_r;
   assign answer_value              = ans_r;
   assign reg_rdata                 = rdata_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_enter_sleep;
      (mode_control != QAW_MODE_SLEEP) && (mode_control != QAW_MODE_OTHER) ##1
      (mode_control == QAW_MODE_SLEEP);
   endsequence

   a_debug_needs_sdm: assert property (
      !software_development_mode |=> !wd_cfg.wd_debug_enable)
      else $error("debug enable set outside development mode");
   a_off_default_back: assert property (
      fail_counter_increment_event || sleep_entry |=> !wd_cfg.wd_standby_off_ctrl)
      else $error("standby off not returned to default");
   a_period_reload: assert property (
      s_enter_sleep |=> wd_cfg.wd_period_select == QAW_PERIOD_RST)
      else $error("period not reloaded on sleep entry");
   a_cause_readback: assert property (
      cause_load && cause_code != QAW_CAUSE_RSVD ##1 reg_rd && reg_addr == QAW_OFS_STATUS && !cause_load
      |=> reg_rdata[7:5] == $past(cause_code, 2))
      else $error("reset cause not reported");
   a_trig_atomic: assert property (
      trig_eval ##1 reg_rd && reg_addr == QAW_OFS_STATUS && !trig_eval
      |=> reg_rdata[4:0] == $past(trig_result, 2))
      else $error("trigger status not taken as one word");
   a_answer_reads_zero: assert property (
      reg_rd && reg_addr == QAW_OFS_ANSWER |=> reg_rdata == 8'h00)
      else $error("answer register did not read zero");
   a_answer_strobe: assert property (
      wr_ans |=> answer_strobe && answer_value == $past(reg_wdata))
      else $error("answer not passed on");
   a_fc_load_two: assert property (
      fail_counter_increment_event |=> fail_counter == QAW_FAILCNT_LOAD)
      else $error("fail counter not loaded with two");
   a_fc_upper_zero: assert property (
      reg_rd && reg_addr == QAW_OFS_FAILCNT |=> reg_rdata[7:2] == 6'h00)
      else $error("fail counter upper bits not zero");
   a_held_standby: assert property (
      watchdog_held_reset_state |-> $past(mode_control) == QAW_MODE_STANDBY && !$past(rxd_int_pending))
      else $error("watchdog held outside standby");
   a_question_follow: assert property (
      reg_rd && reg_addr == QAW_OFS_QUESTION |=> reg_rdata == $past(question_in, 2))
      else $error("question not presented");

   // counter bump also reloads the period and the counter itself
   a_period_on_bump: assert property (
      fail_counter_increment_event |=> wd_cfg.wd_period_select == QAW_PERIOD_RST)
      else $error("period not reloaded on counter increment");
   a_fc_sleep_two: assert property (
      s_enter_sleep |=> fail_counter == QAW_FAILCNT_LOAD)
      else $error("fail counter not loaded on sleep entry");
   a_off_rxd_clear: assert property (
      mode_control == QAW_MODE_STANDBY && rxd_int_pending |=> !wd_cfg.wd_standby_off_ctrl)
      else $error("standby off kept with receive pin interrupt");
   a_held_sets: assert property (
      wd_cfg.wd_standby_off_ctrl && mode_control == QAW_MODE_STANDBY && !rxd_int_pending
      |=> watchdog_held_reset_state)
      else $error("watchdog not held in standby");
   // reserved cause code must leave the stored cause alone
   a_cause_rsvd_kept: assert property (
      cause_load && cause_code == QAW_CAUSE_RSVD |=> cause_r == $past(cause_r))
      else $error("reserved reset cause stored");
   a_fc_write_lands: assert property (
      wr_fc && !fail_counter_increment_event && !sleep_entry
      |=> fail_counter == $past(reg_wdata[1:0]))
      else $error("fail counter write lost");
   a_strobe_single: assert property (
      answer_strobe |=> answer_strobe == $past(wr_ans))
      else $error("answer strobe longer than one cycle");
   // trigger status only moves on an evaluation, never half way
   a_trig_hold: assert property (
      !trig_eval |=> trig_r == $past(trig_r))
      else $error("trigger status changed without evaluation");

endmodule : qaw_regs

`default_nettype wire

// >>> sim/qaw_host.sv
// host model: the controller that serves the watchdog over the register port
// assumes tb_top calls its tasks; one byte per access, no overlap
`timescale 1ns/1ns
`default_nettype none

module qaw_host (
   // register port
   input  wire logic       clk,
   output var  logic [7:0] reg_addr,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // one write; data flips on release so stale bytes never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask : wr

   // one read; data stands from the cycle after the request edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask : rd

   // fail count write, upper bits always sent clear
   task automatic wfc(input logic [1:0] v);
      wr(8'h82, {6'h00, v});
   endtask : wfc

   // fetch question, reply with its inverse
   task automatic serve(output logic [7:0] ans);
      logic [7:0] q;
      rd(8'h80, q);
      ans = ~q;
      wr(8'h81, ans);
   endtask : serve
endmodule : qaw_host

`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench of the watchdog register block
// assumes qaw_pkg, qaw_regs and qaw_host are compiled first
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import qaw_pkg::*;
   // ****
   // signals and model state
   // ****
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] reg_addr;
   logic       reg_wr, reg_rd, watchdog_held_reset_state, answer_strobe;
   logic [7:0] reg_wdata, reg_rdata, answer_value, d, question_in = 8'h00;
   qaw_mode_e  mode_control = QAW_MODE_NORMAL;
   logic       software_development_mode = 1'b0, rxd_int_pending = 1'b0;
   logic       fail_counter_increment_event = 1'b0, cause_load = 1'b0;
   logic       trig_eval = 1'b0;
   logic [2:0] cause_code = 3'h0;
   logic [1:0] fail_counter;
   qaw_trig_s  trig_result = QAW_TRIG_RST;
   qaw_cfg_s   wd_cfg;
   int         m_dbg = 0, m_off = 0, m_per = 4, m_fc = 2, m_cause = 0, m_trig = 0;
   int         qv, mismatches = 0, comparisons = 0, cycles = 0;

   qaw_regs dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .mode_control, .software_development_mode, .rxd_int_pending,
      .fail_counter_increment_event, .cause_load, .cause_code, .trig_eval,
      .trig_result, .question_in, .wd_cfg, .watchdog_held_reset_state,
      .fail_counter, .answer_strobe, .answer_value);
   qaw_host host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

   // 50 MHz clock
   always #10 clk = ~clk;

   // ****
   // model, compare and close
   // ****
   function automatic int cfgv();
      return m_dbg * 128 + m_off * 64 + m_per;
   endfunction : cfgv

   function automatic int stv();
      return m_cause * 32 + m_trig;
   endfunction : stv

   // defaults that a counter increment or sleep entry restores
   task automatic reload;
      m_off = 0;
      m_per = 4;
      m_fc = 2;
   endtask : reload

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic rdc(input string n, input logic [7:0] a, input int e);
      logic [7:0] v;
      host.rd(a, v);
      chk(n, 8'(e), v);
   endtask : rdc

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // hang guard, far above the just under two hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         mismatches++;
         end_sim;
      end
   end

   // ****
   // scenarios
   // ****
   initial begin
      void'($urandom(30));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rdc("cfg", QAW_OFS_CONFIG, cfgv());
      rdc("fc", QAW_OFS_FAILCNT, m_fc);
      host.wr(QAW_OFS_STATUS, 8'hff);
      rdc("stat", QAW_OFS_STATUS, stv());
      rdc("unm", 8'h10, 0);
      software_development_mode <= 1'b1;
      host.wr(QAW_OFS_CONFIG, 8'h85);
      rdc("cfg", QAW_OFS_CONFIG, 8'h85);
      software_development_mode <= 1'b0;
      host.wr(QAW_OFS_CONFIG, 8'hfd);
      rdc("cfg", QAW_OFS_CONFIG, 8'h45);
      repeat (4) begin
         m_fc = $urandom_range(3);
         host.wfc(2'(m_fc));
         rdc("fc", QAW_OFS_FAILCNT, m_fc);
      end
      // counter increment, then sleep entry from each awake mode
      host.wr(QAW_OFS_CONFIG, 8'h43);
      host.wfc(2'h0);
      fail_counter_increment_event <= 1'b1;
      @(posedge clk) fail_counter_increment_event <= 1'b0;
      reload;
      rdc("cfg", QAW_OFS_CONFIG, cfgv());
      rdc("fc", QAW_OFS_FAILCNT, m_fc);
      chk("fcout", 8'(m_fc), {6'h00, fail_counter});
      chk("wdcfg", 8'(m_dbg * 16 + m_off * 8 + m_per), {3'h0, wd_cfg});
      for (int i = 0; i < 3; i++) begin
         mode_control <= qaw_mode_e'(i);
         host.wr(QAW_OFS_CONFIG, 8'h43);
         host.wfc(2'h1);
         if (i == 2) chk("held", 8'h01, {7'h00, watchdog_held_reset_state});
         mode_control <= QAW_MODE_SLEEP;
         @(posedge clk);
         reload;
         rdc("cfg", QAW_OFS_CONFIG, cfgv());
         rdc("fc", QAW_OFS_FAILCNT, m_fc);
      end
      // pending receive-pin interrupt keeps the hold from setting and clears off
      mode_control <= QAW_MODE_STANDBY;
      host.wr(QAW_OFS_CONFIG, 8'h44);
      rxd_int_pending <= 1'b1;
      repeat (2) @(posedge clk);
      chk("held", 8'h00, {7'h00, watchdog_held_reset_state});
      rdc("cfg", QAW_OFS_CONFIG, cfgv());
      rxd_int_pending <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         cause_code <= 3'(i);
         cause_load <= 1'b1;
         @(posedge clk) cause_load <= 1'b0;
         if (i != 5) m_cause = i;
         rdc("stat", QAW_OFS_STATUS, stv());
      end
      repeat (6) begin
         m_trig = $urandom_range(31);
         trig_result <= qaw_trig_s'(5'(m_trig));
         trig_eval <= 1'b1;
         @(posedge clk) trig_eval <= 1'b0;
         rdc("stat", QAW_OFS_STATUS, stv());
      end
      // host serves questions; answer echoes out and reads back zero
      repeat (3) begin
         qv = $urandom_range(255);
         question_in <= 8'(qv);
         host.serve(d);
         @(negedge clk);
         chk("stb", 8'h01, {7'h00, answer_strobe});
         chk("ans", 8'(qv) ^ 8'hff, answer_value);
         @(negedge clk);
         chk("stb", 8'h00, {7'h00, answer_strobe});
         rdc("ansrd", QAW_OFS_ANSWER, 0);
      end
      end_sim;
   end
endmodule : tb_top

`default_nettype wire
